// >>> src/dwd_pkg.sv
// shared constants and types for the dual watchdog timer block
// Function
// - system watchdog is a 14-bit down-counter
// - system watchdog underflow can reset the chip
// - system underflow may raise NMI or interrupt
// - refresh allowed only inside configured window
// - independent watchdog 14-bit counter, software services it
// - independent underflow gives reset, NMI or interrupt
// - independent watchdog runs from dedicated oscillator
// - independent restarts on reset, underflow, error, refresh
// - each watchdog reset is a distinct cause
// - dedicated oscillator runs at nominal 15 kHz
package dwd_pkg;

    // ------------------------------------------------------------
    // widths and clock rates
    // ------------------------------------------------------------
    localparam int           CNT_W       = 14;          // counter width
    localparam int           DIV_W       = 16;          // divider width
    localparam longint       SYS_CLK_HZ  = 100000000;   // system clock
    localparam longint       IND_OSC_HZ  = 15000;       // oscillator rate
    // oscillator period in system cycles, rounded down
    localparam int           IND_DIV_CYC = int'(SYS_CLK_HZ / IND_OSC_HZ);
    localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;   // underflow point
    localparam logic [CNT_W-1:0] CNT_ONE  = 14'h0001;   // decrement step
    localparam logic [DIV_W-1:0] DIV_ZERO = 16'h0000;   // divider reset

    // ------------------------------------------------------------
    // response selection and channel state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DWD_RESP_RESET = 2'b00,   // chip reset request
        DWD_RESP_NMI   = 2'b01,   // non-maskable interrupt
        DWD_RESP_IRQ   = 2'b10    // ordinary interrupt
    } dwd_resp_t;

    typedef enum logic [0:0] {
        DWD_ST_IDLE  = 1'b0,      // stopped, counter not running
        DWD_ST_COUNT = 1'b1       // counting down
    } dwd_state_t;

endpackage : dwd_pkg

// >>> src/dwd_channel.sv
// one watchdog channel: down-counter, refresh window and response
`timescale 1ns/1ns
module dwd_channel
    import dwd_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // count control
    input  wire logic             tick_en,
    input  wire logic             run_en,
    input  wire logic             refresh,
    // configuration
    input  wire logic [CNT_W-1:0] init_count,
    input  wire logic [CNT_W-1:0] win_lo,
    input  wire logic [CNT_W-1:0] win_hi,
    input  wire dwd_resp_t        resp_mode,
    // responses and status
    output logic                  rst_q,
    output logic                  nmi_q,
    output logic                  irq_q,
    output logic                  err_q,
    output logic [CNT_W-1:0]      cnt_q
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dwd_state_t       state_q;      // running or stopped
    dwd_state_t       state_d;      // next state
    logic [CNT_W-1:0] cnt_d;        // next count
    logic             rst_d;        // next reset request
    logic             nmi_d;        // next nmi pulse
    logic             irq_d;        // next irq pulse
    logic             err_d;        // next refresh error pulse
    logic             in_win;       // count inside refresh window
    logic             event_hit;    // underflow or refresh error

    // refresh only counts as valid inside the window
    assign in_win = (cnt_q <= win_hi) && (cnt_q >= win_lo);

    // next-value logic for counter, state and responses
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        err_d     = 1'b0;
        event_hit = 1'b0;
        case (state_q)
            // start loads the initial count
            DWD_ST_IDLE: begin
                if (run_en) begin
                    state_d = DWD_ST_COUNT;
                    cnt_d   = init_count;
                end
            end
            // counting down toward zero
            DWD_ST_COUNT: begin
                if (!run_en) begin
                    state_d = DWD_ST_IDLE;
                end else if (refresh) begin
                    cnt_d = init_count;
                    if (!in_win) begin
                        err_d     = 1'b1;
                        event_hit = 1'b1;
                    end
                end else if (tick_en) begin
                    if (cnt_q == CNT_ZERO) begin
                        event_hit = 1'b1;
                        cnt_d     = init_count;
                    end else begin
                        cnt_d = cnt_q - CNT_ONE;
                    end
                end
            end
            default: begin
                state_d = DWD_ST_IDLE;
            end
        endcase
        // steer the event to the configured response
        rst_d = 1'b0;
        nmi_d = 1'b0;
        irq_d = 1'b0;
        case (resp_mode)
            DWD_RESP_NMI: nmi_d = event_hit;
            DWD_RESP_IRQ: irq_d = event_hit;
            default:      rst_d = event_hit;
        endcase
    end

    // registers only
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_q <= DWD_ST_IDLE;
            cnt_q   <= CNT_ZERO;
            rst_q   <= 1'b0;
            nmi_q   <= 1'b0;
            irq_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            rst_q   <= rst_d;
            nmi_q   <= nmi_d;
            irq_q   <= irq_d;
            err_q   <= err_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_live;
        state_q == DWD_ST_COUNT && run_en;
    endsequence
    sequence s_tick_only;
        s_live ##0 (!refresh && tick_en);
    endsequence
    sequence s_underflow;
        s_tick_only ##0 (cnt_q == CNT_ZERO);
    endsequence

    count_step_a: assert property (
        s_tick_only ##0 (cnt_q != CNT_ZERO) |=> cnt_q == $past(cnt_q) - CNT_ONE)
        else $error("counter did not step down by one");
    count_hold_a: assert property (
        s_live ##0 (!refresh && !tick_en) |=> $stable(cnt_q))
        else $error("counter moved without a tick");
    refresh_load_a: assert property (
        s_live ##0 (refresh && in_win)
        |=> cnt_q == $past(init_count) && !err_q && !rst_q)
        else $error("valid refresh did not reload");
    // back-to-back refreshes are legal, so the second cycle follows
    // whatever refresh was taken in the first one
    window_err_a: assert property (
        s_live ##0 (refresh && !in_win) |=> err_q ##1
        (err_q == $past(refresh && !in_win && run_en
                        && state_q == DWD_ST_COUNT)))
        else $error("refresh outside window not flagged");
    err_resp_a: assert property (
        s_live ##0 (refresh && !in_win)
        |=> (rst_q || nmi_q || irq_q) && cnt_q == $past(init_count))
        else $error("refresh error gave no response");
    under_reset_a: assert property (
        s_underflow ##0 (resp_mode == DWD_RESP_RESET)
        |=> rst_q && !nmi_q && !irq_q)
        else $error("underflow did not request reset");
    under_int_a: assert property (
        s_underflow ##0 (resp_mode == DWD_RESP_NMI) |=> nmi_q && !rst_q)
        else $error("underflow did not raise nmi");
    under_irq_a: assert property (
        s_underflow ##0 (resp_mode == DWD_RESP_IRQ) |=> irq_q && !rst_q)
        else $error("underflow did not raise irq");
    under_restart_a: assert property (
        s_underflow |=> state_q == DWD_ST_COUNT
        && cnt_q == $past(init_count))
        else $error("counter did not restart after underflow");

endmodule : dwd_channel

// >>> src/dwd_top.sv
// dual watchdog timers: system-clocked and independent channels
`timescale 1ns/1ns
module dwd_top
    import dwd_pkg::*;
#(
    parameter int IND_DIV = IND_DIV_CYC    // system cycles per osc tick
)
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // system watchdog control
    input  wire logic             sys_run_en,
    input  wire logic             sys_refresh,
    input  wire logic [CNT_W-1:0] sys_init_count,
    input  wire logic [CNT_W-1:0] sys_win_lo,
    input  wire logic [CNT_W-1:0] sys_win_hi,
    input  wire dwd_resp_t        sys_resp_mode,
    // independent watchdog control
    input  wire logic             ind_refresh,
    input  wire logic [CNT_W-1:0] ind_init_count,
    input  wire logic [CNT_W-1:0] ind_win_lo,
    input  wire logic [CNT_W-1:0] ind_win_hi,
    input  wire dwd_resp_t        ind_resp_mode,
    // system watchdog responses and status
    output logic                  sys_reset_cause,
    output logic                  sys_nmi,
    output logic                  sys_irq,
    output logic                  sys_refresh_err,
    output logic [CNT_W-1:0]      sys_count,
    // independent watchdog responses and status
    output logic                  ind_reset_cause,
    output logic                  ind_nmi,
    output logic                  ind_irq,
    output logic                  ind_refresh_err,
    output logic [CNT_W-1:0]      ind_count
);

    // ------------------------------------------------------------
    // dedicated oscillator as an enable pulse
    // ------------------------------------------------------------
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(IND_DIV - 1);

    logic [DIV_W-1:0] div_q;        // oscillator divider
    logic [DIV_W-1:0] div_d;
    logic             osc_tick_q;   // one cycle per oscillator period
    logic             osc_tick_d;

    // divider wraps once per oscillator period
    always_comb begin
        osc_tick_d = (div_q == DIV_LAST);
        div_d      = osc_tick_d ? DIV_ZERO : div_q + 16'h0001;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            div_q      <= DIV_ZERO;
            osc_tick_q <= 1'b0;
        end else begin
            div_q      <= div_d;
            osc_tick_q <= osc_tick_d;
        end
    end

    // ------------------------------------------------------------
    // system-clocked watchdog, counts every system cycle
    // ------------------------------------------------------------
    dwd_channel u_system_watchdog (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .tick_en    (1'b1),
        .run_en     (sys_run_en),
        .refresh    (sys_refresh),
        .init_count (sys_init_count),
        .win_lo     (sys_win_lo),
        .win_hi     (sys_win_hi),
        .resp_mode  (sys_resp_mode),
        .rst_q      (sys_reset_cause),
        .nmi_q      (sys_nmi),
        .irq_q      (sys_irq),
        .err_q      (sys_refresh_err),
        .cnt_q      (sys_count)
    );

    // ------------------------------------------------------------
    // independent watchdog, runs from reset on the oscillator tick
    // ------------------------------------------------------------
    dwd_channel u_independent_watchdog (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .tick_en    (osc_tick_q),
        .run_en     (1'b1),
        .refresh    (ind_refresh),
        .init_count (ind_init_count),
        .win_lo     (ind_win_lo),
        .win_hi     (ind_win_hi),
        .resp_mode  (ind_resp_mode),
        .rst_q      (ind_reset_cause),
        .nmi_q      (ind_nmi),
        .irq_q      (ind_irq),
        .err_q      (ind_refresh_err),
        .cnt_q      (ind_count)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    osc_spacing_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        osc_tick_q |=> !osc_tick_q [*8])
        else $error("oscillator ticks too close together");
    ind_gate_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        !osc_tick_q && !ind_refresh && $past(reset_n)
        && ind_count != CNT_ZERO |=> $stable(ind_count))
        else $error("independent count moved off its clock");

endmodule : dwd_top

// >>> testbench/dwd_top_tb_top.sv
// self-checking bench for the dual watchdog timer block
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_compared++; \
    if ((got) !== (exp)) begin fails++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module dwd_top_tb_top;
    import dwd_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam int DIV = 10;                  // shortened oscillator tick
    logic clk_sys = 1'b0, reset_n = 1'b0;     // clock and reset
    logic sys_run_en = 1'b1, sys_refresh = 1'b0, ind_refresh = 1'b0;
    logic [CNT_W-1:0] sys_init_count, sys_win_lo, sys_win_hi;
    logic [CNT_W-1:0] ind_init_count, ind_win_lo, ind_win_hi;
    dwd_resp_t        sys_resp_mode, ind_resp_mode;
    logic sys_reset_cause, sys_nmi, sys_irq, sys_refresh_err;
    logic ind_reset_cause, ind_nmi, ind_irq, ind_refresh_err;
    logic [CNT_W-1:0] sys_count, ind_count;
    int fails = 0, n_compared = 0;             // verdict counters
    dwd_top #(.IND_DIV(DIV)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .sys_run_en(sys_run_en),
        .sys_refresh(sys_refresh), .sys_init_count(sys_init_count),
        .sys_win_lo(sys_win_lo), .sys_win_hi(sys_win_hi),
        .sys_resp_mode(sys_resp_mode), .ind_refresh(ind_refresh),
        .ind_init_count(ind_init_count), .ind_win_lo(ind_win_lo),
        .ind_win_hi(ind_win_hi), .ind_resp_mode(ind_resp_mode),
        .sys_reset_cause(sys_reset_cause), .sys_nmi(sys_nmi),
        .sys_irq(sys_irq), .sys_refresh_err(sys_refresh_err),
        .sys_count(sys_count), .ind_reset_cause(ind_reset_cause),
        .ind_nmi(ind_nmi), .ind_irq(ind_irq),
        .ind_refresh_err(ind_refresh_err), .ind_count(ind_count));
    always #5 clk_sys = ~clk_sys;              // 100 MHz
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // inputs change and outputs are read 1 ns after each rising edge
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask : step
    task automatic do_reset();
        reset_n = 1'b0;
        repeat (4) step();
        reset_n = 1'b1;
    endtask : do_reset
    // expected response pulses; mode 11 behaves as reset
    task automatic chk_resp(input logic [1:0] m, input logic on,
                            input logic r, input logic n, input logic i);
        `CHK("rst", on && (m == 2'b00 || m == 2'b11), r)
        `CHK("nmi", on && m == 2'b01, n)
        `CHK("irq", on && m == 2'b10, i)
    endtask : chk_resp
    task automatic wait_sys(input logic [CNT_W-1:0] v);
        for (int k = 0; k < 300 && sys_count !== v; k++) step();
    endtask : wait_sys
    task automatic wait_ind(input logic [CNT_W-1:0] v);
        for (int k = 0; k < 300 && ind_count !== v; k++) step();
    endtask : wait_ind
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // system counter runs down to zero, then underflows and reloads
    task automatic sys_underflow(input logic [1:0] m);
        sys_resp_mode  = dwd_resp_t'(m);
        sys_init_count = 14'h0003;
        do_reset();
        wait_sys(14'h0002);
        step();
        `CHK("sys_count", 14'h0001, sys_count)
        step();
        `CHK("sys_count", 14'h0000, sys_count)
        step();
        `CHK("sys_count", 14'h0003, sys_count)
        chk_resp(m, 1'b1, sys_reset_cause, sys_nmi, sys_irq);
        `CHK("ind_rst", 1'b0, ind_reset_cause)
        step();
        chk_resp(m, 1'b0, sys_reset_cause, sys_nmi, sys_irq);
    endtask : sys_underflow
    // refresh inside then outside the permitted window
    task automatic sys_window();
        sys_init_count = 14'h0064;
        sys_win_lo     = 14'h0032;
        sys_win_hi     = 14'h003C;
        do_reset();
        wait_sys(14'h0037);
        sys_refresh = 1'b1;
        step();
        sys_refresh = 1'b0;
        `CHK("sys_count", 14'h0064, sys_count)
        `CHK("sys_err", 1'b0, sys_refresh_err)
        // let one edge pass so the strobe is not re-driven in one step
        step();
        `CHK("sys_count", 14'h0063, sys_count)
        for (int m = 0; m < 4; m++) begin
            sys_resp_mode = dwd_resp_t'(m[1:0]);
            sys_refresh   = 1'b1;
            step();
            sys_refresh   = 1'b0;
            `CHK("sys_err", 1'b1, sys_refresh_err)
            `CHK("sys_count", 14'h0064, sys_count)
            chk_resp(m[1:0], 1'b1, sys_reset_cause, sys_nmi, sys_irq);
            step();
            `CHK("sys_err", 1'b0, sys_refresh_err)
            chk_resp(m[1:0], 1'b0, sys_reset_cause, sys_nmi, sys_irq);
        end
        sys_win_lo = 14'h0000;
        sys_win_hi = 14'h3FFF;
    endtask : sys_window
    // independent counter ticks every DIV cycles, underflows, restarts
    task automatic ind_run(input logic [1:0] m);
        int n;
        ind_resp_mode = dwd_resp_t'(m);
        sys_run_en    = 1'b0;
        do_reset();
        step();
        sys_refresh = 1'b1;
        step();
        sys_refresh = 1'b0;
        step();
        `CHK("sys_count", 14'h0000, sys_count)
        `CHK("sys_err", 1'b0, sys_refresh_err)
        wait_ind(14'h0001);
        for (n = 0; n < 50 && ind_count === 14'h0001; n++) step();
        `CHK("ind_tick", DIV, n)
        `CHK("ind_count", 14'h0000, ind_count)
        for (n = 0; n < 50 && ind_count === 14'h0000; n++) step();
        `CHK("ind_tick", DIV, n)
        `CHK("ind_count", 14'h0002, ind_count)
        chk_resp(m, 1'b1, ind_reset_cause, ind_nmi, ind_irq);
        `CHK("sys_rst", 1'b0, sys_reset_cause)
        step();
        chk_resp(m, 1'b0, ind_reset_cause, ind_nmi, ind_irq);
        wait_ind(14'h0001);
        ind_refresh = 1'b1;
        step();
        // hold the refresh; the window now excludes the reloaded count
        ind_win_hi = 14'h0001;
        `CHK("ind_count", 14'h0002, ind_count)
        `CHK("ind_err", 1'b0, ind_refresh_err)
        step();
        ind_refresh = 1'b0;
        ind_win_hi  = 14'h3FFF;
        `CHK("ind_err", 1'b1, ind_refresh_err)
        `CHK("ind_count", 14'h0002, ind_count)
        chk_resp(m, 1'b1, ind_reset_cause, ind_nmi, ind_irq);
        step();
        `CHK("ind_err", 1'b0, ind_refresh_err)
        chk_resp(m, 1'b0, ind_reset_cause, ind_nmi, ind_irq);
    endtask : ind_run
    // ----------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ----------------------------------------------------------------
    task automatic give_verdict();
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #(20000 * 10);
        fails++;
        give_verdict();
    end
    initial begin
        sys_win_lo     = 14'h0000;
        sys_win_hi     = 14'h3FFF;
        ind_init_count = 14'h0002;
        ind_win_lo     = 14'h0000;
        ind_win_hi     = 14'h3FFF;
        ind_resp_mode  = DWD_RESP_RESET;
        for (int m = 0; m < 4; m++) sys_underflow(m[1:0]);
        sys_window();
        for (int m = 0; m < 3; m++) ind_run(m[1:0]);
        give_verdict();
    end
endmodule : dwd_top_tb_top
